/* hw/abt_block_tx_host.sv */
// Host controller that writes block packets into the device's transmit FIFO.
// Assumes the device raises its full pin early enough to absorb five more writes.
`timescale 1ns/1ps

// Contract
// - Write the packet information quadlet first, then two quadlets of 64-bit address.
// - Fourth quadlet: byte count high 16 bits, extended code low 16; payload follows.
// - First quadlet: speed 17:16, label 15:10, retry 9:8, code 7:4, priority 3:0.
// - Each outstanding transaction carries its own distinct label; responses match by label.
// - Retry code: 00 new, 01 retry X, 10 retry A, 11 retry B.
// - Priority field is always zero on cable.
// - Destination is a 10-bit bus number followed by a 6-bit node number.
// - The 48-bit destination offset is a multiple of four.
// - For lock responses the top four offset-high bits carry the response code; rest reserved.
// - A zero length means no payload quadlets follow the header.
// - The first payload byte sits in byte 0 of the first payload quadlet.
// - Response codes 0, 4, 5, 6, 7 are defined; all others are reserved.
module abt_block_tx_host
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Command
  input  wire logic              cmd_valid,
  input  wire abt_pkg::abt_cmd_t cmd,
  output logic                   cmd_ready,
  output logic                   cmd_done,
  output logic                   cmd_error,
  output logic [5:0]             cmd_label,
  // Payload bytes
  input  wire logic [7:0]        pay_byte,
  input  wire logic              pay_valid,
  output logic                   pay_ready,
  // Label release
  input  wire logic              free_valid,
  input  wire logic [5:0]        free_label,
  // Device transmit FIFO pins
  output logic [31:0]            fifo_data,
  output logic                   fifo_wr,
  input  wire logic              fifo_full
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    abt_pkg::abt_state_t            st;
    abt_pkg::abt_cmd_t              cmd;
    logic [5:0]                     label;
    logic [14:0]                    qcnt;
    abt_pkg::abt_fifo_t             fifo;
    abt_pkg::abt_state_t            kind;
    logic                           ready;
    logic                           done;
    logic                           error;
    logic [abt_pkg::SYNC_STAGES-1:0] sync;
    logic                           full;
  } abt_host_t;

  abt_host_t q;
  abt_host_t d;

  logic        accept;
  logic        start;
  logic        alloc;
  logic        avail;
  logic [5:0]  pool_label;
  logic [31:0] word;
  logic        word_valid;
  logic        take;

  assign cmd_ready = q.ready;
  assign cmd_done  = q.done;
  assign cmd_error = q.error;
  assign cmd_label = q.label;
  assign fifo_data = q.fifo.data;
  assign fifo_wr   = q.fifo.wr;

  assign accept = (q.st == abt_pkg::ST_IDLE) && q.ready && cmd_valid;
  assign start  = accept && abt_pkg::cmd_ok(cmd);
  assign alloc  = (q.st == abt_pkg::ST_WAIT) && avail;
  assign take   = (q.st == abt_pkg::ST_DATA) && word_valid && !q.full;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  abt_label_pool u_pool
  (
    .clock      (clock),
    .reset_n    (reset_n),
    .alloc      (alloc),
    .avail      (avail),
    .label      (pool_label),
    .free_valid (free_valid),
    .free_label (free_label)
  );

  abt_byte_packer u_pack
  (
    .clock      (clock),
    .reset_n    (reset_n),
    .start      (start),
    .length     (cmd.length),
    .in_byte    (pay_byte),
    .in_valid   (pay_valid),
    .in_ready   (pay_ready),
    .word       (word),
    .word_valid (word_valid),
    .take       (take)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    d         = q;
    d.fifo.wr = 1'b0;
    d.done    = 1'b0;
    d.error   = 1'b0;
    // Full pin is trusted only once two later stages agree
    d.sync    = {q.sync[1:0], fifo_full};
    if (q.sync[1] == q.sync[2])
    begin
      d.full = q.sync[2];
    end
    case (q.st)
      abt_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          if (!abt_pkg::cmd_ok(cmd))
          begin
            // Bad speed, misaligned offset or reserved response code
            d.error = 1'b1;
          end
          else
          begin
            d.cmd = cmd;
            if (cmd.is_resp)
            begin
              // A response reuses the label of the request it answers
              d.label = cmd.tlabel;
              d.st    = abt_pkg::ST_HDR0;
            end
            else
            begin
              d.st = abt_pkg::ST_WAIT;
            end
          end
        end
      end
      abt_pkg::ST_WAIT:
      begin
        if (avail)
        begin
          d.label = pool_label;
          d.st    = abt_pkg::ST_HDR0;
        end
      end
      abt_pkg::ST_HDR0, abt_pkg::ST_HDR1, abt_pkg::ST_HDR2, abt_pkg::ST_HDR3:
      begin
        if (!q.full)
        begin
          // Header quadlets go out strictly in order
          d.fifo.wr   = 1'b1;
          d.fifo.data = abt_pkg::hdr_quadlet(q.cmd, q.st, q.label);
          d.kind      = q.st;
          case (q.st)
            abt_pkg::ST_HDR0: d.st = abt_pkg::ST_HDR1;
            abt_pkg::ST_HDR1: d.st = abt_pkg::ST_HDR2;
            abt_pkg::ST_HDR2: d.st = abt_pkg::ST_HDR3;
            default:
            begin
              d.qcnt = abt_pkg::quadlets(q.cmd.length);
              if (q.cmd.length == 16'h0000)
              begin
                d.st   = abt_pkg::ST_IDLE;
                d.done = 1'b1;
              end
              else
              begin
                d.st = abt_pkg::ST_DATA;
              end
            end
          endcase
        end
      end
      abt_pkg::ST_DATA:
      begin
        if (take)
        begin
          d.fifo.wr   = 1'b1;
          d.fifo.data = word;
          d.kind      = abt_pkg::ST_DATA;
          d.qcnt      = q.qcnt - 15'h0001;
          if (q.qcnt == 15'h0001)
          begin
            d.st   = abt_pkg::ST_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default:
      begin
        d.st = abt_pkg::ST_IDLE;
      end
    endcase
    d.ready = (d.st == abt_pkg::ST_IDLE);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic wr0;
  logic wr1;
  logic wr2;
  logic wr3;
  logic wrd;

  assign wr0 = q.fifo.wr && (q.kind == abt_pkg::ST_HDR0);
  assign wr1 = q.fifo.wr && (q.kind == abt_pkg::ST_HDR1);
  assign wr2 = q.fifo.wr && (q.kind == abt_pkg::ST_HDR2);
  assign wr3 = q.fifo.wr && (q.kind == abt_pkg::ST_HDR3);
  assign wrd = q.fifo.wr && (q.kind == abt_pkg::ST_DATA);

  sequence s_last_hdr_empty;
    wr3 && (q.cmd.length == 16'h0000);
  endsequence

  sequence s_back_to_idle;
    (q.st == abt_pkg::ST_IDLE) && q.done && !wrd;
  endsequence

  a_hdr_order: assert property (wr1 |-> $past(q.st, 2) == abt_pkg::ST_HDR0 || $past(q.st, 2) == abt_pkg::ST_HDR1)
    else $error("address quadlet written before packet information");
  a_info_fields: assert property (wr0 |-> q.fifo.data[17:16] == q.cmd.spd && q.fifo.data[15:10] == q.label
    && q.fifo.data[9:8] == q.cmd.rt && q.fifo.data[7:4] == q.cmd.tcode)
    else $error("packet information fields misplaced");
  a_speed_legal: assert property (wr0 |-> q.fifo.data[17:16] != abt_pkg::SPD_UNDEF)
    else $error("undefined speed code written");
  a_prio_zero: assert property (wr0 |-> q.fifo.data[3:0] == abt_pkg::PRIO_CABLE)
    else $error("priority not zero");
  a_dest_split: assert property (wr1 |-> q.fifo.data[31:22] == q.cmd.bus && q.fifo.data[21:16] == q.cmd.node)
    else $error("destination bus or node misplaced");
  a_offset_aligned: assert property ((wr2 && !q.cmd.is_resp) |-> q.fifo.data[1:0] == 2'h0)
    else $error("offset not quadlet aligned");
  a_rcode_field: assert property ((wr1 && q.cmd.is_resp) |-> q.fifo.data[15:12] == q.cmd.rcode
    && q.fifo.data[11:0] == 12'h000 && abt_pkg::rcode_legal(q.fifo.data[15:12]))
    else $error("response code field wrong");
  a_len_quadlet: assert property (wr3 |-> q.fifo.data == {q.cmd.length, q.cmd.ext_tcode}
    && (q.st == abt_pkg::ST_IDLE || q.qcnt == abt_pkg::quadlets(q.cmd.length)))
    else $error("length quadlet or quadlet count wrong");
  a_zero_len: assert property (s_last_hdr_empty |-> s_back_to_idle ##1 !q.fifo.wr)
    else $error("payload written after zero length");
  a_pad_zero: assert property ((wrd && q.st == abt_pkg::ST_IDLE)
    |-> (q.fifo.data & abt_pkg::pad_mask(q.cmd.length)) == 32'h00000000)
    else $error("final quadlet pad bytes not zero");
  a_data_count: assert property ((q.st == abt_pkg::ST_DATA && d.st == abt_pkg::ST_IDLE)
    |-> q.qcnt == 15'h0001 ##1 wrd && q.done)
    else $error("payload quadlet count wrong");

endmodule // abt_block_tx_host

/* hw/abt_pkg.sv */
// Constants, types and header-building functions for the block-transmit host.
// Assumes the device reads big-endian quadlets: byte 0 sits in bits 31:24.
package abt_pkg;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int          SPD_LSB      = 16;
  localparam int          TLABEL_LSB   = 10;
  localparam int          RT_LSB       = 8;
  localparam int          TCODE_LSB    = 4;
  localparam int          LEN_LSB      = 16;
  localparam int          RCODE_LSB    = 12;
  localparam int          BUS_W        = 10;
  localparam int          NODE_W       = 6;
  localparam int          SYNC_STAGES  = 3;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0]  SPD_100      = 2'h0;
  localparam logic [1:0]  SPD_200      = 2'h1;
  localparam logic [1:0]  SPD_400      = 2'h2;
  localparam logic [1:0]  SPD_UNDEF    = 2'h3;
  localparam logic [1:0]  RT_NEW       = 2'h0;
  localparam logic [1:0]  RT_X         = 2'h1;
  localparam logic [1:0]  RT_A         = 2'h2;
  localparam logic [1:0]  RT_B         = 2'h3;
  localparam logic [3:0]  PRIO_CABLE   = 4'h0;
  localparam logic [3:0]  RC_COMPLETE  = 4'h0;
  localparam logic [3:0]  RC_CONFLICT  = 4'h4;
  localparam logic [3:0]  RC_DATA      = 4'h5;
  localparam logic [3:0]  RC_TYPE      = 4'h6;
  localparam logic [3:0]  RC_ADDRESS   = 4'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [1:0]        spd;
    logic [5:0]        tlabel;
    logic [1:0]        rt;
    logic [3:0]        tcode;
    logic [BUS_W-1:0]  bus;
    logic [NODE_W-1:0] node;
    logic [47:0]       offset;
    logic              is_resp;
    logic [3:0]        rcode;
    logic [15:0]       length;
    logic [15:0]       ext_tcode;
  } abt_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_HDR0 = 3'b010,
    ST_HDR1 = 3'b011,
    ST_HDR2 = 3'b100,
    ST_HDR3 = 3'b101,
    ST_DATA = 3'b110
  } abt_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic        wr;
  } abt_fifo_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic rcode_legal(logic [3:0] rc);
    return (rc == RC_COMPLETE) || (rc == RC_CONFLICT) || (rc == RC_DATA) ||
           (rc == RC_TYPE) || (rc == RC_ADDRESS);
  endfunction

  function automatic logic cmd_ok(abt_cmd_t c);
    return (c.spd != SPD_UNDEF) && (c.is_resp ? rcode_legal(c.rcode) : (c.offset[1:0] == 2'h0));
  endfunction

  function automatic logic [14:0] quadlets(logic [15:0] len);
    logic [16:0] s;
    s = {1'b0, len} + 17'h00003;
    return s[16:2];
  endfunction

  function automatic logic [31:0] hdr_quadlet(abt_cmd_t c, abt_state_t st, logic [5:0] lbl);
    case (st)
      ST_HDR0: return {14'h0000, c.spd, lbl, c.rt, c.tcode, PRIO_CABLE};
      ST_HDR1: return c.is_resp ? {c.bus, c.node, c.rcode, 12'h000} : {c.bus, c.node, c.offset[47:32]};
      ST_HDR2: return c.is_resp ? 32'h00000000 : c.offset[31:0];
      default: return {c.length, c.ext_tcode};
    endcase
  endfunction

  // Mask of the pad bytes in the final payload quadlet
  function automatic logic [31:0] pad_mask(logic [15:0] len);
    case (len[1:0])
      2'h1:    return 32'h00ffffff;
      2'h2:    return 32'h0000ffff;
      2'h3:    return 32'h000000ff;
      default: return 32'h00000000;
    endcase
  endfunction

endpackage

/* hw/abt_label_pool.sv */
// Transaction label pool: hands out free labels and takes them back.
// Assumes the user returns a label once the matching response is seen.
`timescale 1ns/1ps

module abt_label_pool
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Allocation
  input  wire logic       alloc,
  output logic            avail,
  output logic [5:0]      label,
  // Release
  input  wire logic       free_valid,
  input  wire logic [5:0] free_label
);

  typedef struct packed {
    logic [63:0] busy;
  } abt_pool_t;

  abt_pool_t q;
  abt_pool_t d;

  function automatic logic [6:0] first_free(logic [63:0] busy);
    logic [6:0] r;
    r = 7'h40;
    for (int i = 63; i >= 0; i--)
    begin
      if (!busy[i])
      begin
        r = 7'(i);
      end
    end
    return r;
  endfunction

  logic [6:0] pick;

  assign pick  = first_free(q.busy);
  assign avail = !pick[6];
  assign label = pick[5:0];

  // Allocation wins over a release of the same label in one cycle
  always_comb
  begin
    d = q;
    if (free_valid)
    begin
      d.busy[free_label] = 1'b0;
    end
    if (alloc && avail)
    begin
      d.busy[label] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  a_label_distinct: assert property (@(posedge clock) disable iff (!reset_n)
    alloc |-> (avail && !q.busy[label]) ##1 q.busy[$past(label)])
    else $error("label handed out while still outstanding");

endmodule // abt_label_pool

/* hw/abt_byte_packer.sv */
// Packs a payload byte stream into quadlets, first byte in bits 31:24.
// Assumes the byte count is loaded by start before any byte is offered.
`timescale 1ns/1ps

module abt_byte_packer
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Control
  input  wire logic        start,
  input  wire logic [15:0] length,
  // Byte stream in
  input  wire logic [7:0]  in_byte,
  input  wire logic        in_valid,
  output logic             in_ready,
  // Quadlet out
  output logic [31:0]      word,
  output logic             word_valid,
  input  wire logic        take
);

  typedef struct packed {
    logic [31:0] word;
    logic [1:0]  lane;
    logic [15:0] left;
    logic        full;
    logic        ready;
  } abt_pack_t;

  abt_pack_t q;
  abt_pack_t d;

  assign in_ready   = q.ready;
  assign word       = q.word;
  assign word_valid = q.full;

  always_comb
  begin
    d = q;
    if (start)
    begin
      d      = '0;
      d.left = length;
    end
    else
    begin
      if (take)
      begin
        // Clearing here leaves zero pad bytes in a short final quadlet
        d.full = 1'b0;
        d.word = 32'h00000000;
        d.lane = 2'h0;
      end
      if (in_valid && q.ready)
      begin
        d.word[{2'(2'h3 - q.lane), 3'h0} +: 8] = in_byte;
        d.lane = q.lane + 2'h1;
        d.left = q.left - 16'h0001;
        if ((q.lane == 2'h3) || (q.left == 16'h0001))
        begin
          d.full = 1'b1;
        end
      end
    end
    d.ready = !d.full && (d.left != 16'h0000);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  a_first_lane: assert property (@(posedge clock) disable iff (!reset_n)
    (in_valid && q.ready && !start && (q.lane == 2'h0)) |=> (q.word[31:24] == $past(in_byte)))
    else $error("first byte of a quadlet not in byte 0");

endmodule // abt_byte_packer

/* verification/abt_fifo_model.sv */
// Device transmit FIFO model: occupancy, full pin and header parsing.
// Assumes the device drains one word per clock unless the bench stalls it.
`timescale 1ns/1ps

module abt_fifo_model
#(
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Write side
  input  wire logic [31:0] fifo_data,
  input  wire logic        fifo_wr,
  output logic             fifo_full,
  // Bench control and status
  input  wire logic        stall,
  output logic             ovf,
  output logic             bad
);
  int          occ_q;
  int          occ_d;
  int          idx_q;
  int          left_q;
  logic [15:0] op_q;

  assign occ_d = occ_q + (fifo_wr ? 1 : 0) - ((!stall && occ_q > 0) ? 1 : 0);

  // ****************************************************************
  // Occupancy and parsing
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      occ_q     <= 0;
      idx_q     <= 0;
      left_q    <= 0;
      op_q      <= 16'h0000;
      fifo_full <= 1'b0;
      ovf       <= 1'b0;
      bad       <= 1'b0;
    end
    else
    begin
      occ_q <= occ_d;
      // Full leaves five free slots: three sync stages, the host's full register and its write register let five writes through
      fifo_full <= (occ_d >= DEPTH - 5);
      if (occ_d > DEPTH)
        ovf <= 1'b1;
      if (fifo_wr)
      begin
        if (idx_q == 0 && (fifo_data[17:16] == 2'h3 || fifo_data[3:0] != 4'h0))
          bad <= 1'b1;
        if (idx_q == 3)
        begin
          op_q   <= fifo_data[15:0];
          left_q <= (int'(fifo_data[31:16]) + 3) / 4;
          idx_q  <= (fifo_data[31:16] == 16'h0000) ? 0 : 4;
        end
        else if (idx_q == 4)
        begin
          left_q <= left_q - 1;
          idx_q  <= (left_q == 1) ? 0 : 4;
        end
        else
          idx_q <= idx_q + 1;
      end
    end
  end
endmodule // abt_fifo_model

/* verification/tb.sv */
// Self-checking bench for the block-transmit host.
// Assumes the FIFO model stands in for the device's transmit FIFO.
`timescale 1ns/1ps

module tb;
  logic              clock, reset_n, cmd_valid, cmd_ready, cmd_done, cmd_error;
  logic              pay_valid, pay_ready, free_valid, fifo_wr, fifo_full;
  logic              stall, chaos, ovf, bad;
  abt_pkg::abt_cmd_t cmd;
  abt_pkg::abt_cmd_t c;
  logic [5:0]        cmd_label, free_label;
  logic [7:0]        pay_byte;
  logic [31:0]       fifo_data;
  logic [63:0]       busy;
  logic [31:0]       exp_q[$];
  int                error_cnt, checked, cycles, seed;

  abt_block_tx_host dut (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error), .cmd_label(cmd_label),
    .pay_byte(pay_byte), .pay_valid(pay_valid), .pay_ready(pay_ready), .free_valid(free_valid),
    .free_label(free_label), .fifo_data(fifo_data), .fifo_wr(fifo_wr), .fifo_full(fifo_full));

  abt_fifo_model model (.clock(clock), .reset_n(reset_n), .fifo_data(fifo_data), .fifo_wr(fifo_wr),
    .fifo_full(fifo_full), .stall(stall), .ovf(ovf), .bad(bad));

  // ****************************************************************
  // Clock, timeout, checking
  // ****************************************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Every device write takes the oldest expected word
  always @(posedge clock)
    if (reset_n === 1'b1 && fifo_wr === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(fifo_data, exp_q.pop_front());
    end

  // Random stalls so the full pin really rises
  always @(negedge clock)
    stall <= chaos && ($random(seed) % 4 != 0);

  // ****************************************************************
  // Stimulus tasks
  // ****************************************************************
  function automatic abt_pkg::abt_cmd_t rnd();
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    return r[$bits(abt_pkg::abt_cmd_t)-1:0];
  endfunction

  function automatic logic [5:0] low_free();
    for (int i = 63; i >= 0; i--)
      if (!busy[i])
        low_free = 6'(i);
  endfunction

  task automatic send(abt_pkg::abt_cmd_t k, int n, logic refuse);
    int          t;
    logic [31:0] w;
    logic [7:0]  b[$];
    logic [5:0]  lbl;
    lbl = k.is_resp ? k.tlabel : low_free();
    w = 32'h0;
    if (!refuse)
    begin
      exp_q.push_back({14'h0000, k.spd, lbl, k.rt, k.tcode, 4'h0});
      exp_q.push_back(k.is_resp ? {k.bus, k.node, k.rcode, 12'h000} : {k.bus, k.node, k.offset[47:32]});
      exp_q.push_back(k.is_resp ? 32'h00000000 : k.offset[31:0]);
      exp_q.push_back({k.length, k.ext_tcode});
      for (int i = 0; i < n; i++)
      begin
        b.push_back(8'($random(seed)));
        w[31-8*(i%4) -: 8] = b[i];
        if (i % 4 == 3 || i == n - 1)
        begin
          exp_q.push_back(w);
          w = 32'h0;
        end
      end
    end
    @(negedge clock);
    cmd = k;
    cmd_valid = 1'b1;
    t = 0;
    do @(posedge clock) t++; while (cmd_ready !== 1'b1 && t < 50);
    @(negedge clock);
    cmd_valid = 1'b0;
    check(t >= 50, 1'b0);
    check(cmd_error, refuse);
    check(cmd_ready, refuse);
    if (refuse)
      return;
    foreach (b[i])
    begin
      pay_byte = b[i];
      pay_valid = 1'b1;
      t = 0;
      do @(posedge clock) t++; while (pay_ready !== 1'b1 && t < 200);
      @(negedge clock);
    end
    pay_valid = 1'b0;
    t = 0;
    do @(posedge clock) t++; while (cmd_done !== 1'b1 && t < 600);
    @(negedge clock);
    check(t >= 600, 1'b0);
    check(exp_q.size(), 0);
    check(cmd_label, lbl);
    if (!k.is_resp)
      busy[lbl] = 1'b1;
  endtask

  task automatic free(logic [5:0] l);
    @(negedge clock);
    free_label = l;
    free_valid = 1'b1;
    @(negedge clock);
    free_valid = 1'b0;
    busy[l] = 1'b0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = 32'h7fe1;
    {error_cnt, checked, cycles} = '0;
    {reset_n, cmd_valid, pay_valid, free_valid, chaos} = '0;
    {pay_byte, free_label, busy} = '0;
    cmd = '0;
    repeat (5) @(negedge clock);
    check(cmd_ready, 1'b0);
    check(fifo_wr, 1'b0);
    reset_n = 1'b1;
    // Responses over every response code, retry code and legal speed
    for (int k = 0; k < 16; k++)
    begin
      c = rnd();
      c.is_resp = 1'b1;
      c.rcode = 4'(k);
      c.rt = 2'(k);
      c.spd = 2'(k % 3);
      c.length = 16'h0000;
      send(c, 0, !(k == 0 || (k >= 4 && k <= 7)));
    end
    c.spd = 2'h3;
    send(c, 0, 1'b1);
    c = rnd();
    c.is_resp = 1'b0;
    c.spd = 2'h1;
    c.offset[1:0] = 2'h2;
    send(c, 0, 1'b1);
    // Requests of every short length, labels reused once freed
    for (int k = 0; k < 10; k++)
    begin
      c = rnd();
      c.is_resp = 1'b0;
      c.spd = 2'(k % 3);
      c.offset[1:0] = 2'h0;
      c.length = 16'(k);
      send(c, k, 1'b0);
      if (k == 2)
        free(6'h01);
    end
    // Long packet against a stalling device
    chaos = 1'b1;
    c.length = 16'h003d;
    send(c, 61, 1'b0);
    chaos = 1'b0;
    repeat (30) @(negedge clock);
    check(ovf, 1'b0);
    check(bad, 1'b0);
    tally_and_finish();
  end
endmodule // tb
